// file: rtl/cpurf_pkg.sv
// What this block does
// - Eight 16-bit general registers, also reachable as sixteen byte registers.
// - A register used as an operand address is always read as 16 bits.
// - Data access reads or writes a whole word, or either byte alone.
// - The eighth register is the stack pointer, moved implicitly on calls and interrupts.
// - The 16-bit program counter holds the next instruction; its bit 0 reads zero.
// - Flag byte: mask, two user bits, half-carry, negative, zero, overflow, carry.
// - With the mask set, only the non-maskable interrupt is accepted.
// - Reset and the start of exception handling force the mask to one.
// - The two user bits are plain storage with no hardware effect.
// - Word add, subtract, compare set half-carry on carry out of bit 11.
// - Decimal adjust after add and subtract consults the half-carry flag.
// - Negative flag takes the sign bit of each flag-affecting result.
// - Zero flag is set for a zero result and cleared otherwise.
// - Overflow flag is set on arithmetic overflow and cleared otherwise.
// - Carry holds add/subtract carry, the bit shifted out, or the bit accumulator.
// - The flag byte can be loaded, stored, and changed by AND, OR, XOR immediates.
// - Conditional branches are decided from negative, zero, overflow and carry.
// - Reset loads the program counter from the reset vector and sets the mask.
// - Pushed flags form a word of two copies; a pop uses only the upper byte.
//
// Constants, enumerations and carriers shared by the register file and its users.
// Assumes one core clock and a datapath that sequences every request.

package cpurf_pkg;

    localparam int          GPR_COUNT  = 8;
    localparam logic [2:0]  SP_INDEX   = 3'h7;
    localparam int          CCR_I      = 7;
    localparam int          CCR_U1     = 6;
    localparam int          CCR_H      = 5;
    localparam int          CCR_U0     = 4;
    localparam int          CCR_N      = 3;
    localparam int          CCR_Z      = 2;
    localparam int          CCR_V      = 1;
    localparam int          CCR_C      = 0;
    localparam logic [7:0]  CCR_RESET  = 8'h80;
    localparam logic [15:0] GPR_RESET  = 16'h0000;
    localparam logic [15:0] SP_STEP    = 16'h0002;
    localparam logic [14:0] PC_STEP    = 15'h0001;
    localparam logic [7:0]  BCD_HIGH   = 8'h60;
    localparam logic [7:0]  BCD_LOW    = 8'h06;

    typedef enum logic {SIZE_BYTE, SIZE_WORD} cpurf_size_type;

    typedef enum logic [3:0] {
        ALU_NONE, ALU_ADD, ALU_ADDX, ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG,
        ALU_LOGIC, ALU_SHIFT, ALU_BITC, ALU_DAA, ALU_DAS
    } cpurf_alu_type;

    typedef enum logic [2:0] {
        CCR_KEEP, CCR_LOAD, CCR_AND, CCR_OR, CCR_XOR, CCR_POP
    } cpurf_ccr_type;

    typedef enum logic [1:0] {SP_KEEP, SP_PUSH, SP_POP} cpurf_sp_type;

    typedef struct packed {
        logic           en;
        logic [3:0]     idx;
        cpurf_size_type size;
        logic [15:0]    data;
    } cpurf_wr_type;

    typedef struct packed {
        cpurf_alu_type  op;
        cpurf_size_type size;
        logic [15:0]    a;
        logic [15:0]    b;
        logic           bitIn;
    } cpurf_alu_req_type;

endpackage

// file: rtl/cpurf_register_file.sv
// Programmer-visible register set of the CPU core: general registers,
// program counter and flag byte, with flag generation for the datapath.
// Assumes the decoder sequences requests and holds each for one mclk cycle.

`timescale 1ns/10ps
`default_nettype none

module cpurf_register_file
    import cpurf_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [15:0]       resetVector,
    input  wire logic [3:0]        rdIdxA,
    input  wire cpurf_size_type    rdSizeA,
    output logic      [15:0]       rdDataA,
    input  wire logic [3:0]        rdIdxB,
    input  wire cpurf_size_type    rdSizeB,
    output logic      [15:0]       rdDataB,
    input  wire logic [2:0]        addrIdx,
    output logic      [15:0]       addrValue,
    input  wire cpurf_wr_type      wrReq,
    input  wire cpurf_sp_type      spOp,
    output logic      [15:0]       stackTop,
    input  wire logic              pcLoad,
    input  wire logic [15:0]       pcTarget,
    input  wire logic              pcAdvance,
    output logic      [15:0]       pcValue,
    input  wire cpurf_alu_req_type aluReq,
    output logic      [15:0]       aluResult,
    input  wire cpurf_ccr_type     ccrOp,
    input  wire logic [15:0]       ccrOperand,
    output logic      [7:0]        ccrValue,
    output logic      [15:0]       ccrPushWord,
    input  wire logic              excStart,
    input  wire logic              irqRequest,
    input  wire logic              nmiRequest,
    output logic                   intAccept,
    input  wire logic [3:0]        branchCond,
    output logic                   branchTaken
);

    // ==========================================================
    // General registers
    // ==========================================================

    logic [15:0] gpr [GPR_COUNT];

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < GPR_COUNT; i++)
            begin
                gpr[i] <= GPR_RESET;
            end
        end
        else
        begin
            // Implicit stack moves first so an explicit write to the same register wins
            case (spOp)
                SP_PUSH: gpr[SP_INDEX] <= gpr[SP_INDEX] - SP_STEP;
                SP_POP:  gpr[SP_INDEX] <= gpr[SP_INDEX] + SP_STEP;
                default: ;
            endcase
            if (wrReq.en)
            begin
                if (wrReq.size == SIZE_WORD)
                begin
                    gpr[wrReq.idx[2:0]] <= wrReq.data;
                end
                else if (wrReq.idx[3])
                begin
                    gpr[wrReq.idx[2:0]][7:0] <= wrReq.data[7:0];
                end
                else
                begin
                    gpr[wrReq.idx[2:0]][15:8] <= wrReq.data[7:0];
                end
            end
        end
    end

    // Byte index 0..7 selects the upper halves, 8..15 the lower halves
    function automatic logic [15:0] readView(input logic [3:0] idx, input cpurf_size_type size,
                                              input logic [15:0] word);
        logic [15:0] view;
        view = word;
        if (size == SIZE_BYTE)
        begin
            view = idx[3] ? {8'h00, word[7:0]} : {8'h00, word[15:8]};
        end
        return view;
    endfunction

    always_comb
    begin
        rdDataA = readView(rdIdxA, rdSizeA, gpr[rdIdxA[2:0]]);
        rdDataB = readView(rdIdxB, rdSizeB, gpr[rdIdxB[2:0]]);
    end

    assign addrValue = gpr[addrIdx];
    assign stackTop  = gpr[SP_INDEX];

    // ==========================================================
    // Program counter
    // ==========================================================

    logic [14:0] pcWord;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pcWord <= resetVector[15:1];
        end
        else if (pcLoad)
        begin
            pcWord <= pcTarget[15:1];
        end
        else if (pcAdvance)
        begin
            pcWord <= pcWord + PC_STEP;
        end
    end

    assign pcValue = {pcWord, 1'b0};

    // ==========================================================
    // Adder and flag generation
    // ==========================================================

    logic [7:0]  condition_flags;
    logic        isSub;
    logic        isArith;
    logic        carryIn;
    logic [15:0] addX;
    logic [15:0] addY;
    logic [4:0]  nibSum;
    logic [12:0] midSum;
    logic [8:0]  byteSum;
    logic [16:0] wordSum;
    logic [15:0] sum;
    logic        carryOut;
    logic        halfOut;
    logic        signX;
    logic        signY;
    logic        signR;

    always_comb
    begin
        isSub   = (aluReq.op == ALU_SUB) || (aluReq.op == ALU_SUBX) ||
                  (aluReq.op == ALU_CMP) || (aluReq.op == ALU_NEG);
        isArith = isSub || (aluReq.op == ALU_ADD) || (aluReq.op == ALU_ADDX);
        addX    = aluReq.a;
        addY    = aluReq.b;
        carryIn = 1'b0;
        case (aluReq.op)
            ALU_ADDX: carryIn = condition_flags[CCR_C];
            ALU_SUB,
            ALU_CMP:
            begin
                addY    = ~aluReq.b;
                carryIn = 1'b1;
            end
            ALU_SUBX:
            begin
                addY    = ~aluReq.b;
                carryIn = ~condition_flags[CCR_C];
            end
            ALU_NEG:
            begin
                addX    = 16'h0000;
                addY    = ~aluReq.a;
                carryIn = 1'b1;
            end
            default: ;
        endcase
        nibSum  = {1'b0, addX[3:0]} + {1'b0, addY[3:0]} + {4'h0, carryIn};
        midSum  = {1'b0, addX[11:0]} + {1'b0, addY[11:0]} + {12'h000, carryIn};
        byteSum = {1'b0, addX[7:0]} + {1'b0, addY[7:0]} + {8'h00, carryIn};
        wordSum = {1'b0, addX} + {1'b0, addY} + {16'h0000, carryIn};
        if (aluReq.size == SIZE_WORD)
        begin
            sum      = wordSum[15:0];
            carryOut = wordSum[16] ^ isSub;
            halfOut  = midSum[12] ^ isSub;
            signX    = addX[15];
            signY    = addY[15];
            signR    = wordSum[15];
        end
        else
        begin
            sum      = {8'h00, byteSum[7:0]};
            carryOut = byteSum[8] ^ isSub;
            halfOut  = nibSum[4] ^ isSub;
            signX    = addX[7];
            signY    = addY[7];
            signR    = byteSum[7];
        end
    end

    // Decimal adjust of a byte, steered by the half-carry and carry flags
    logic [7:0] bcdAdj;
    logic [7:0] bcdOut;
    logic       bcdCarry;

    always_comb
    begin
        bcdAdj   = 8'h00;
        bcdCarry = condition_flags[CCR_C];
        if (aluReq.op == ALU_DAA)
        begin
            if (condition_flags[CCR_C] || (aluReq.a[7:0] > 8'h99))
            begin
                bcdAdj   = BCD_HIGH;
                bcdCarry = 1'b1;
            end
            if (condition_flags[CCR_H] || (aluReq.a[3:0] > 4'h9))
            begin
                bcdAdj = bcdAdj + BCD_LOW;
            end
            bcdOut = aluReq.a[7:0] + bcdAdj;
        end
        else
        begin
            if (condition_flags[CCR_C])
            begin
                bcdAdj = BCD_HIGH;
            end
            if (condition_flags[CCR_H])
            begin
                bcdAdj = bcdAdj + BCD_LOW;
            end
            bcdOut = aluReq.a[7:0] - bcdAdj;
        end
    end

    // Result seen by N and Z; logic and shift results arrive on operand a
    logic [15:0] flagSrc;
    logic        flagSign;

    always_comb
    begin
        if (isArith)
        begin
            flagSrc = sum;
        end
        else if ((aluReq.op == ALU_DAA) || (aluReq.op == ALU_DAS))
        begin
            flagSrc = {8'h00, bcdOut};
        end
        else if (aluReq.size == SIZE_WORD)
        begin
            flagSrc = aluReq.a;
        end
        else
        begin
            flagSrc = {8'h00, aluReq.a[7:0]};
        end
        flagSign = (aluReq.size == SIZE_WORD) ? flagSrc[15] : flagSrc[7];
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            aluResult <= 16'h0000;
        end
        else if ((aluReq.op != ALU_NONE) && (aluReq.op != ALU_CMP) && (aluReq.op != ALU_BITC))
        begin
            aluResult <= flagSrc;
        end
    end

    // ==========================================================
    // Flag byte
    // ==========================================================

    logic [7:0] next_ccr;

    always_comb
    begin
        next_ccr = condition_flags;
        case (ccrOp)
            CCR_LOAD: next_ccr = ccrOperand[7:0];
            CCR_AND:  next_ccr = condition_flags & ccrOperand[7:0];
            CCR_OR:   next_ccr = condition_flags | ccrOperand[7:0];
            CCR_XOR:  next_ccr = condition_flags ^ ccrOperand[7:0];
            CCR_POP:  next_ccr = ccrOperand[15:8];
            default:
            begin
                case (aluReq.op)
                    ALU_ADD, ALU_ADDX, ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG:
                    begin
                        next_ccr[CCR_H] = halfOut;
                        next_ccr[CCR_N] = flagSign;
                        next_ccr[CCR_Z] = (flagSrc == 16'h0000);
                        next_ccr[CCR_V] = (signX == signY) && (signR != signX);
                        next_ccr[CCR_C] = carryOut;
                    end
                    ALU_LOGIC:
                    begin
                        next_ccr[CCR_N] = flagSign;
                        next_ccr[CCR_Z] = (flagSrc == 16'h0000);
                        next_ccr[CCR_V] = 1'b0;
                    end
                    ALU_SHIFT:
                    begin
                        next_ccr[CCR_N] = flagSign;
                        next_ccr[CCR_Z] = (flagSrc == 16'h0000);
                        next_ccr[CCR_V] = 1'b0;
                        next_ccr[CCR_C] = aluReq.bitIn;
                    end
                    ALU_BITC: next_ccr[CCR_C] = aluReq.bitIn;
                    ALU_DAA, ALU_DAS:
                    begin
                        next_ccr[CCR_N] = flagSign;
                        next_ccr[CCR_Z] = (flagSrc == 16'h0000);
                        next_ccr[CCR_C] = bcdCarry;
                    end
                    default: ;
                endcase
            end
        endcase
        if (excStart)
        begin
            next_ccr[CCR_I] = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            condition_flags <= CCR_RESET;
        end
        else
        begin
            condition_flags <= next_ccr;
        end
    end

    assign ccrValue    = condition_flags;
    assign ccrPushWord = {condition_flags, condition_flags};

    // ==========================================================
    // Interrupt gate and branch conditions
    // ==========================================================

    assign intAccept = nmiRequest || (irqRequest && !condition_flags[CCR_I]);

    logic fn;
    logic fz;
    logic fv;
    logic fc;

    always_comb
    begin
        fn = condition_flags[CCR_N];
        fz = condition_flags[CCR_Z];
        fv = condition_flags[CCR_V];
        fc = condition_flags[CCR_C];
        case (branchCond)
            4'h0:    branchTaken = 1'b1;
            4'h1:    branchTaken = 1'b0;
            4'h2:    branchTaken = !(fc || fz);
            4'h3:    branchTaken = fc || fz;
            4'h4:    branchTaken = !fc;
            4'h5:    branchTaken = fc;
            4'h6:    branchTaken = !fz;
            4'h7:    branchTaken = fz;
            4'h8:    branchTaken = !fv;
            4'h9:    branchTaken = fv;
            4'hA:    branchTaken = !fn;
            4'hB:    branchTaken = fn;
            4'hC:    branchTaken = !(fn ^ fv);
            4'hD:    branchTaken = fn ^ fv;
            4'hE:    branchTaken = !(fz || (fn ^ fv));
            default: branchTaken = fz || (fn ^ fv);
        endcase
    end

endmodule

`default_nettype wire

// file: tb/cpurf_register_file_sva.sv
// Checker for the CPU register file: program counter, flag byte, stack pointer, branch and interrupt gating.
// Assumes it is bound to cpurf_register_file and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module cpurf_register_file_sva
    import cpurf_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic [15:0]   resetVector,
    input  wire cpurf_wr_type  wrReq,
    input  wire cpurf_sp_type  spOp,
    input  wire logic [15:0]   stackTop,
    input  wire logic          pcLoad,
    input  wire logic [15:0]   pcTarget,
    input  wire logic          pcAdvance,
    input  wire logic [15:0]   pcValue,
    input  wire cpurf_ccr_type ccrOp,
    input  wire logic [15:0]   ccrOperand,
    input  wire logic [7:0]    ccrValue,
    input  wire logic [15:0]   ccrPushWord,
    input  wire logic          excStart,
    input  wire logic          irqRequest,
    input  wire logic          nmiRequest,
    input  wire logic          intAccept,
    input  wire logic [3:0]    branchCond,
    input  wire logic          branchTaken
);

// ==========================================
// Assertions
default clocking cb @(posedge mclk);
endclocking
default disable iff (sys_rst);

a_reset_load: assert property ($fell(sys_rst) |-> ccrValue[CCR_I] && pcValue == ($past(resetVector) & 16'hFFFE))
    else $error("reset did not load vector and mask");
a_exc_mask: assert property (excStart |=> ccrValue[CCR_I])
    else $error("exception start left mask clear");
a_int_gate: assert property (intAccept == (nmiRequest | (irqRequest & ~ccrValue[CCR_I])))
    else $error("interrupt gating wrong");
a_push_copies: assert property (ccrPushWord == {ccrValue, ccrValue})
    else $error("pushed flag word not two copies");
a_pop_upper: assert property (ccrOp == CCR_POP && !excStart |=> {ccrValue, 8'h00} == ($past(ccrOperand) & 16'hFF00))
    else $error("pop did not take upper byte");
a_and_bits: assert property (ccrOp == CCR_AND && !excStart
    |=> {8'h00, ccrValue} == ($past(ccrOperand) & {8'h00, $past(ccrValue)}))
    else $error("flag AND wrong");
a_pc_advance: assert property (pcAdvance && !pcLoad |=> pcValue == $past(pcValue) + 16'h0002)
    else $error("pc advance wrong");
a_pc_load: assert property (pcLoad |=> pcValue == ($past(pcTarget) & 16'hFFFE))
    else $error("pc load wrong");
a_sp_push: assert property (spOp == SP_PUSH && !wrReq.en |=> stackTop == $past(stackTop) - SP_STEP)
    else $error("stack push wrong");
a_branch_eq: assert property (branchCond == 4'h7 |-> branchTaken == ccrValue[CCR_Z])
    else $error("equal branch wrong");

c_pop: cover property (ccrOp == CCR_POP);
c_exc_irq: cover property (excStart && irqRequest);
c_sp_pop: cover property (spOp == SP_POP);

endmodule

bind cpurf_register_file cpurf_register_file_sva u_sva (
    .mclk(mclk), .sys_rst(sys_rst), .resetVector(resetVector), .wrReq(wrReq), .spOp(spOp),
    .stackTop(stackTop), .pcLoad(pcLoad), .pcTarget(pcTarget), .pcAdvance(pcAdvance), .pcValue(pcValue),
    .ccrOp(ccrOp), .ccrOperand(ccrOperand), .ccrValue(ccrValue), .ccrPushWord(ccrPushWord),
    .excStart(excStart), .irqRequest(irqRequest), .nmiRequest(nmiRequest), .intAccept(intAccept),
    .branchCond(branchCond), .branchTaken(branchTaken)
);

`default_nettype wire

// file: tb/cpurf_datapath_model.sv
// Stand-in for the decoder side: drives register writes and stack moves.
// Assumes its tasks are called from the bench; each request holds for one mclk edge.
`timescale 1ns/10ps
`default_nettype none

module cpurf_datapath_model
    import cpurf_pkg::*;
(
    input  wire logic         mclk,
    output var cpurf_wr_type  wrReq,
    output var cpurf_sp_type  spOp
);

initial
begin
    wrReq = '0;
    spOp = SP_KEEP;
end

// ==========================================
// Requests
task automatic wr(input logic [3:0] idx, input cpurf_size_type size, input logic [15:0] data);
    @(posedge mclk);
    #1;
    wrReq = '{1'b1, idx, size, data};
    @(posedge mclk);
    #1;
    wrReq = '0;
endtask

task automatic sp(input cpurf_sp_type op);
    @(posedge mclk);
    #1;
    spOp = op;
    @(posedge mclk);
    #1;
    spOp = SP_KEEP;
endtask

// Stack pointer is loaded before anything else uses it
task automatic init_sp(input logic [15:0] top);
    wr(4'h7, SIZE_WORD, top);
endtask

endmodule

`default_nettype wire

// file: tb/test_cpu_register_file_and_flags.sv
// Self-checking bench for the CPU register file.
// Assumes the bound checker and the datapath stand-in from this folder.
`timescale 1ns/10ps
`default_nettype none

module test_cpu_register_file_and_flags
    import cpurf_pkg::*;
;

logic              mclk = 1'b0;
logic              sys_rst = 1'b1;
logic [15:0]       resetVector = 16'h1235;
logic [3:0]        rdIdxA = '0, rdIdxB = '0, branchCond = '0;
cpurf_size_type    rdSizeA = SIZE_WORD, rdSizeB = SIZE_BYTE;
logic [2:0]        addrIdx = '0;
logic              pcLoad = 1'b0, pcAdvance = 1'b0, excStart = 1'b0, irqRequest = 1'b0, nmiRequest = 1'b0;
logic [15:0]       pcTarget = '0, ccrOperand = '0;
cpurf_alu_req_type aluReq = '0;
logic              aluBit = 1'b0;
cpurf_ccr_type     ccrOp = CCR_KEEP;
cpurf_wr_type      wrReq;
cpurf_sp_type      spOp;
logic [15:0]       rdDataA, rdDataB, addrValue, stackTop, pcValue, aluResult, ccrPushWord;
logic [7:0]        ccrValue;
logic              intAccept, branchTaken;
int                fails = 0, cmp_count = 0;

always #10 mclk = ~mclk;

cpurf_datapath_model u_dp (.mclk(mclk), .wrReq(wrReq), .spOp(spOp));

cpurf_register_file u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .resetVector(resetVector), .rdIdxA(rdIdxA), .rdSizeA(rdSizeA),
    .rdDataA(rdDataA), .rdIdxB(rdIdxB), .rdSizeB(rdSizeB), .rdDataB(rdDataB), .addrIdx(addrIdx),
    .addrValue(addrValue), .wrReq(wrReq), .spOp(spOp), .stackTop(stackTop), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .pcAdvance(pcAdvance), .pcValue(pcValue), .aluReq(aluReq), .aluResult(aluResult),
    .ccrOp(ccrOp), .ccrOperand(ccrOperand), .ccrValue(ccrValue), .ccrPushWord(ccrPushWord),
    .excStart(excStart), .irqRequest(irqRequest), .nmiRequest(nmiRequest), .intAccept(intAccept),
    .branchCond(branchCond), .branchTaken(branchTaken)
);

// ==========================================
// Helpers
task automatic end_sim();
    if (fails == 0 && cmp_count > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask

task automatic step();
    @(posedge mclk);
    #1;
endtask

task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    cmp_count++;
    if (got !== want)
    begin
        fails++;
        $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
    end
endtask

task automatic alu(input cpurf_alu_type op, input cpurf_size_type size, input logic [15:0] a, input logic [15:0] b);
    step();
    aluReq = '{op, size, a, b, aluBit};
    step();
    aluReq = '0;
endtask

task automatic condition_flags(input cpurf_ccr_type op, input logic [15:0] v);
    step();
    ccrOp = op;
    ccrOperand = v;
    step();
    ccrOp = CCR_KEEP;
endtask

task automatic pc(input logic ld, input logic adv, input logic [15:0] tgt);
    step();
    pcLoad = ld;
    pcAdvance = adv;
    pcTarget = tgt;
    step();
    pcLoad = 1'b0;
    pcAdvance = 1'b0;
endtask

task automatic br(input logic [3:0] c, input logic want);
    step();
    branchCond = c;
    #1;
    chk(branchTaken, want, "branch");
endtask

// ==========================================
// Scenarios
task automatic t_regs();
    logic [15:0] want;
    for (int i = 0; i < GPR_COUNT; i++)
        u_dp.wr(4'(i), SIZE_WORD, 16'h1111 * 16'(i) + 16'h0F05);
    for (int i = 0; i < GPR_COUNT; i++)
    begin
        want = 16'h1111 * 16'(i) + 16'h0F05;
        step();
        rdIdxA = 4'(i);
        rdIdxB = 4'(i);
        addrIdx = 3'(i);
        #1;
        chk(rdDataA, want, "word read");
        chk(addrValue, want, "address read");
        chk(rdDataB, {8'h00, want[15:8]}, "upper byte");
        step();
        rdIdxB = 4'(i + 8);
        #1;
        chk(rdDataB, {8'h00, want[7:0]}, "lower byte");
    end
    u_dp.wr(4'h8, SIZE_BYTE, 16'h00AB);
    u_dp.wr(4'h0, SIZE_BYTE, 16'h00CD);
    rdIdxA = 4'h0;
    #1;
    chk(rdDataA, 16'hCDAB, "byte writes");
    step();
    rdSizeA = SIZE_BYTE;
    rdIdxA = 4'h8;
    #1;
    chk(rdDataA, 16'h00AB, "byte view");
endtask

task automatic t_stack();
    u_dp.init_sp(16'h0400);
    u_dp.sp(SP_PUSH);
    chk(stackTop, 16'h03FE, "push");
    u_dp.sp(SP_POP);
    rdSizeA = SIZE_WORD;
    rdIdxA = 4'h7;
    #1;
    chk(rdDataA, 16'h0400, "pop");
endtask

task automatic t_pc();
    pc(1'b1, 1'b0, 16'hABCD);
    chk(pcValue, 16'hABCC, "pc load");
    pc(1'b0, 1'b1, 16'h0000);
    chk(pcValue, 16'hABCE, "pc advance");
    pc(1'b1, 1'b1, 16'h0101);
    chk(pcValue, 16'h0100, "pc load wins");
endtask

task automatic t_ccr();
    condition_flags(CCR_LOAD, 16'h0000);
    chk(ccrValue, 8'h00, "flag load");
    condition_flags(CCR_OR, 16'h0050);
    chk(ccrValue, 8'h50, "user bits");
    condition_flags(CCR_XOR, 16'h00F0);
    chk(ccrValue, 8'hA0, "flag xor");
    condition_flags(CCR_AND, 16'h003F);
    chk(ccrValue, 8'h20, "flag and");
    condition_flags(CCR_POP, 16'h5A33);
    chk(ccrPushWord, 16'h5A5A, "pop and push");
endtask

task automatic t_alu();
    alu(ALU_ADD, SIZE_BYTE, 16'h0008, 16'h0008);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b10000, "byte half carry");
    alu(ALU_DAA, SIZE_BYTE, 16'h0010, 16'h0000);
    chk(aluResult, 16'h0016, "decimal adjust");
    alu(ALU_ADD, SIZE_BYTE, 16'h0080, 16'h0080);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b00111, "byte overflow");
    alu(ALU_ADD, SIZE_WORD, 16'h7FFF, 16'h0001);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b11010, "word add");
    alu(ALU_SUB, SIZE_BYTE, 16'h0000, 16'h0001);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b11001, "byte borrow");
    chk({ccrValue[CCR_U1], ccrValue[CCR_U0]}, 2'b11, "user bits kept");
endtask

task automatic t_irq();
    condition_flags(CCR_LOAD, 16'h0080);
    irqRequest = 1'b1;
    #1;
    chk(intAccept, 1'b0, "irq masked");
    step();
    nmiRequest = 1'b1;
    #1;
    chk(intAccept, 1'b1, "nmi passes");
    step();
    nmiRequest = 1'b0;
    condition_flags(CCR_LOAD, 16'h0000);
    chk(intAccept, 1'b1, "irq open");
    step();
    excStart = 1'b1;
    step();
    excStart = 1'b0;
    chk(intAccept, 1'b0, "exception masks");
    irqRequest = 1'b0;
endtask

task automatic t_branch();
    condition_flags(CCR_LOAD, 16'h0004);
    br(4'h7, 1'b1);
    br(4'h6, 1'b0);
    br(4'h0, 1'b1);
    br(4'h1, 1'b0);
    condition_flags(CCR_LOAD, 16'h0008);
    br(4'hB, 1'b1);
    br(4'hA, 1'b0);
    br(4'hD, 1'b1);
    br(4'hC, 1'b0);
endtask

task automatic t_ops();
    condition_flags(CCR_LOAD, 16'h0001);
    alu(ALU_ADDX, SIZE_BYTE, 16'h00FF, 16'h0000);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b10101, "add with carry");
    alu(ALU_SUBX, SIZE_BYTE, 16'h0005, 16'h0003);
    chk(aluResult, 16'h0001, "subtract with borrow");
    alu(ALU_CMP, SIZE_WORD, 16'h1234, 16'h1234);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b00100, "compare flags");
    chk(aluResult, 16'h0001, "compare keeps result");
    alu(ALU_NEG, SIZE_BYTE, 16'h0001, 16'h0000);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b11001, "negate flags");
    chk(aluResult, 16'h00FF, "negate");
    alu(ALU_LOGIC, SIZE_BYTE, 16'h0000, 16'h0000);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b10101, "logic flags");
    alu(ALU_SHIFT, SIZE_BYTE, 16'h0080, 16'h0000);
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b11000, "shift flags");
    aluBit = 1'b1;
    alu(ALU_BITC, SIZE_BYTE, 16'h0000, 16'h0000);
    aluBit = 1'b0;
    chk({ccrValue[CCR_H], ccrValue[3:0]}, 5'b11001, "bit carry");
    alu(ALU_DAS, SIZE_BYTE, 16'h0099, 16'h0000);
    chk(aluResult, 16'h0033, "decimal adjust sub");
endtask

initial
begin
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk(pcValue, 16'h1234, "reset pc");
    chk(ccrValue[CCR_I], 1'b1, "reset mask");
    t_regs();
    t_stack();
    t_pc();
    t_ccr();
    t_alu();
    t_irq();
    t_branch();
    t_ops();
    end_sim();
end

initial
begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_sim();
end

endmodule

`default_nettype wire
